// file: logic/tlsc_top.sv
// Trajectory load and stop control with APB register access
//
// What this block does
// - Load command starts taking a control word and parameters into input buffers.
// - Start command copies buffered parameters to working registers and starts motion.
// - Buffered parameters affect nothing until a start command executes.
// - Low byte 0A hex loads velocity and position, both absolute.
// - Each parameter is two words, high first; velocity before position.
// - Low byte 00 hex loads no parameters; old values stay.
// - Position mode ends smoothly and automatically at the trajectory end.
// - Control bits eight to ten pick the stop mode, applied at next start.
// - Bit eight stops by forcing drive to the offset-binary zero code.
// - Bit nine stops abruptly by setting desired position to actual position.
// - Bit ten stops smoothly at the last programmed acceleration.
// - After abrupt or smooth stop the loop holds the resting position.
// - After motor-off stop desired position follows actual position.
// - A start with no new parameters restarts the retained move.
// - High byte holds mode, direction, stop; low byte parameter selection.
// - Any parameter mix loads at once; zero to six words follow.
// - Reset clears trajectory parameters so a bare start holds position.
`timescale 1ns/1ns
module tlsc_top #(
  parameter int SAMPLE_CLKS = tlsc_pkg::SAMPLE_CLKS,
  parameter int POS_W = 32
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tlsc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Servo loop side
  input wire logic [POS_W-1:0] actual_pos,
  input wire logic [tlsc_pkg::DRIVE_W-1:0] pid_drive,
  output logic [tlsc_pkg::DRIVE_W-1:0] motor_drive,
  output logic [POS_W-1:0] desired_pos,
  output logic in_motion
);

  localparam int BUSY_W = $clog2(tlsc_pkg::BUSY_CYCLES + 1);
  localparam int TICK_W = $clog2(SAMPLE_CLKS);
  localparam logic [BUSY_W-1:0] BUSY_LOAD = BUSY_W'(tlsc_pkg::BUSY_CYCLES);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(SAMPLE_CLKS - 1);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [31:0] prdata_q, prdata_d, rd_mux;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic addr_ok, acc_wr, cmd_wr, data_wr, busy, word_done;
  logic [BUSY_W-1:0] busy_q, busy_d;
  logic [TICK_W-1:0] tick_q, tick_d;
  logic tick;
  tlsc_pkg::tlsc_ld_e ld_q, ld_d;
  logic byte_lo_q, byte_lo_d, word_lo_q, word_lo_d;
  logic [7:0] high_byte_q, high_byte_d;
  logic [15:0] word;
  logic [15:0] ctrl_q, ctrl_d;
  logic [2:0] pend_q, pend_d, ldflag_q, ldflag_d, rel_q, rel_d;
  logic [1:0] sel;
  logic [POS_W-1:0] buf_q [tlsc_pkg::NUM_PAR];
  logic [POS_W-1:0] buf_d [tlsc_pkg::NUM_PAR];
  logic [POS_W-1:0] work_q [tlsc_pkg::NUM_PAR];
  logic [POS_W-1:0] work_d [tlsc_pkg::NUM_PAR];
  logic start_q, start_d, vel_mode_q, vel_mode_d, fwd_q, fwd_d;
  logic motor_off_q, motor_off_d;
  logic [2:0] stop_q, stop_d;
  logic [tlsc_pkg::DRIVE_W-1:0] drive_q, drive_d;
  logic [POS_W-1:0] prof_pos;
  logic prof_moving;

  // ----------------------------------------------------------------
  // APB slave, zero wait states, answer registered in setup
  // ----------------------------------------------------------------
  always_comb begin
    addr_ok = (paddr == tlsc_pkg::ADDR_CMD) || (paddr == tlsc_pkg::ADDR_DATA) ||
              (paddr == tlsc_pkg::ADDR_STATUS) || (paddr == tlsc_pkg::ADDR_CTRL) ||
              (paddr == tlsc_pkg::ADDR_DES_POS) || (paddr == tlsc_pkg::ADDR_TGT_POS);
    rd_mux = '0;
    unique case (paddr)
      tlsc_pkg::ADDR_STATUS: begin
        rd_mux[tlsc_pkg::ST_BUSY] = busy;
        rd_mux[tlsc_pkg::ST_MOVING] = prof_moving;
        rd_mux[tlsc_pkg::ST_MOTOR_OFF] = motor_off_q;
        rd_mux[tlsc_pkg::ST_LOADING] = (ld_q != tlsc_pkg::TLSC_LD_IDLE);
      end
      tlsc_pkg::ADDR_CTRL: rd_mux[15:0] = ctrl_q;
      tlsc_pkg::ADDR_DES_POS: rd_mux = 32'(prof_pos);
      tlsc_pkg::ADDR_TGT_POS: rd_mux = 32'(work_q[tlsc_pkg::PAR_POS]);
      default: rd_mux = '0;
    endcase
    pready_d = psel && !penable;
    pslverr_d = psel && !penable && !addr_ok;
    prdata_d = (psel && !penable && !pwrite) ? rd_mux : prdata_q;
    acc_wr = psel && penable && pready_q && pwrite && addr_ok;
    // Writes during busy are dropped; software must poll first
    cmd_wr = acc_wr && (paddr == tlsc_pkg::ADDR_CMD) && !busy;
    data_wr = acc_wr && (paddr == tlsc_pkg::ADDR_DATA) && !busy;
  end

  // ----------------------------------------------------------------
  // Busy flag and sample tick
  // ----------------------------------------------------------------
  assign busy = (busy_q != '0);
  assign word_done = data_wr && byte_lo_q;
  assign tick = (tick_q == TICK_LAST);

  always_comb begin
    busy_d = busy ? busy_q - 1'b1 : busy_q;
    if (cmd_wr || word_done) begin
      busy_d = BUSY_LOAD;
    end
    tick_d = tick ? '0 : tick_q + 1'b1;
  end

  // ----------------------------------------------------------------
  // Command and data loader
  // ----------------------------------------------------------------
  always_comb begin
    word = {high_byte_q, pwdata[7:0]};
    sel = pend_q[tlsc_pkg::PAR_ACC] ? 2'(tlsc_pkg::PAR_ACC) :
          pend_q[tlsc_pkg::PAR_VEL] ? 2'(tlsc_pkg::PAR_VEL) : 2'(tlsc_pkg::PAR_POS);
    ld_d = ld_q;
    byte_lo_d = byte_lo_q;
    word_lo_d = word_lo_q;
    high_byte_d = high_byte_q;
    ctrl_d = ctrl_q;
    pend_d = pend_q;
    ldflag_d = ldflag_q;
    rel_d = rel_q;
    buf_d = buf_q;
    start_d = 1'b0;
    if (cmd_wr) begin
      byte_lo_d = 1'b0;
      word_lo_d = 1'b0;
      ld_d = tlsc_pkg::TLSC_LD_IDLE;
      if (pwdata[7:0] == tlsc_pkg::LOAD_TRAJECTORY_CMD) begin
        ld_d = tlsc_pkg::TLSC_LD_CTRL;
      end else if (pwdata[7:0] == tlsc_pkg::START_MOTION_CMD) begin
        start_d = 1'b1;
      end
    end else if (data_wr) begin
      byte_lo_d = !byte_lo_q;
      if (!byte_lo_q) begin
        high_byte_d = pwdata[7:0];
      end
    end
    if (word_done) begin
      unique case (ld_q)
        tlsc_pkg::TLSC_LD_IDLE: begin
        end
        tlsc_pkg::TLSC_LD_CTRL: begin
          ctrl_d = word;
          pend_d[tlsc_pkg::PAR_POS] = word[tlsc_pkg::CW_POS_LD];
          pend_d[tlsc_pkg::PAR_VEL] = word[tlsc_pkg::CW_VEL_LD];
          pend_d[tlsc_pkg::PAR_ACC] = word[tlsc_pkg::CW_ACC_LD];
          rel_d[tlsc_pkg::PAR_POS] = word[tlsc_pkg::CW_POS_REL];
          rel_d[tlsc_pkg::PAR_VEL] = word[tlsc_pkg::CW_VEL_REL];
          rel_d[tlsc_pkg::PAR_ACC] = word[tlsc_pkg::CW_ACC_REL];
          ldflag_d = '0;
          // Empty selection ends the sequence, buffers untouched
          ld_d = (pend_d == '0) ? tlsc_pkg::TLSC_LD_IDLE : tlsc_pkg::TLSC_LD_PARAM;
          word_lo_d = 1'b0;
        end
        tlsc_pkg::TLSC_LD_PARAM: begin
          if (word_lo_q) begin
            buf_d[sel][15:0] = word;
            pend_d[sel] = 1'b0;
            ldflag_d[sel] = 1'b1;
            if (pend_d == '0) begin
              ld_d = tlsc_pkg::TLSC_LD_IDLE;
            end
          end else begin
            buf_d[sel][POS_W-1:16] = (POS_W - 16)'(word);
          end
          word_lo_d = !word_lo_q;
        end
        default: ld_d = tlsc_pkg::TLSC_LD_IDLE;
      endcase
    end
    if (start_d) begin
      // Stop bits are one-shot so a later start resumes the move
      ctrl_d[tlsc_pkg::CW_SMOOTH:tlsc_pkg::CW_MOTOR_OFF] = '0;
      ldflag_d = '0;
    end
  end

  // ----------------------------------------------------------------
  // Working registers, touched only by a start
  // ----------------------------------------------------------------
  always_comb begin
    work_d = work_q;
    stop_d = stop_q;
    vel_mode_d = vel_mode_q;
    fwd_d = fwd_q;
    motor_off_d = motor_off_q;
    if (start_d) begin
      for (int i = 0; i < tlsc_pkg::NUM_PAR; i++) begin
        if (ldflag_q[i]) begin
          work_d[i] = rel_q[i] ? work_q[i] + buf_q[i] : buf_q[i];
        end
      end
      stop_d = ctrl_q[tlsc_pkg::CW_SMOOTH:tlsc_pkg::CW_STOP_LSB];
      vel_mode_d = ctrl_q[tlsc_pkg::CW_VEL_MODE];
      fwd_d = ctrl_q[tlsc_pkg::CW_FORWARD];
      motor_off_d = ctrl_q[tlsc_pkg::CW_MOTOR_OFF];
    end
    drive_d = motor_off_q ? tlsc_pkg::DRIVE_ZERO_CODE : pid_drive;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      busy_q <= '0;
      tick_q <= '0;
      ld_q <= tlsc_pkg::TLSC_LD_IDLE;
      byte_lo_q <= 1'b0;
      word_lo_q <= 1'b0;
      high_byte_q <= '0;
      ctrl_q <= '0;
      pend_q <= '0;
      ldflag_q <= '0;
      rel_q <= '0;
      start_q <= 1'b0;
      stop_q <= '0;
      vel_mode_q <= 1'b0;
      fwd_q <= 1'b0;
      motor_off_q <= 1'b0;
      drive_q <= tlsc_pkg::DRIVE_ZERO_CODE;
      for (int i = 0; i < tlsc_pkg::NUM_PAR; i++) begin
        buf_q[i] <= '0;
        work_q[i] <= '0;
      end
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      busy_q <= busy_d;
      tick_q <= tick_d;
      ld_q <= ld_d;
      byte_lo_q <= byte_lo_d;
      word_lo_q <= word_lo_d;
      high_byte_q <= high_byte_d;
      ctrl_q <= ctrl_d;
      pend_q <= pend_d;
      ldflag_q <= ldflag_d;
      rel_q <= rel_d;
      start_q <= start_d;
      stop_q <= stop_d;
      vel_mode_q <= vel_mode_d;
      fwd_q <= fwd_d;
      motor_off_q <= motor_off_d;
      drive_q <= drive_d;
      buf_q <= buf_d;
      work_q <= work_d;
    end
  end

  // ----------------------------------------------------------------
  // Profile generator; start delayed one cycle so working regs settle
  // ----------------------------------------------------------------
  tlsc_profile #(
    .POS_W(POS_W)
  ) u_profile (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .start(start_q),
    .stop_mode(stop_q),
    .vel_mode(vel_mode_q),
    .forward(fwd_q),
    .acc(work_q[tlsc_pkg::PAR_ACC]),
    .vmax(work_q[tlsc_pkg::PAR_VEL]),
    .target(work_q[tlsc_pkg::PAR_POS]),
    .actual(actual_pos),
    .desired_pos(prof_pos),
    .moving(prof_moving)
  );

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign motor_drive = drive_q;
  assign desired_pos = prof_pos;
  assign in_motion = prof_moving;

endmodule : tlsc_top

// file: logic/tlsc_pkg.sv
// Constants shared by the trajectory load and stop control block
package tlsc_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] LOAD_TRAJECTORY_CMD = 8'h1F;
  localparam logic [7:0] START_MOTION_CMD = 8'h01;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_CMD = 12'h000;
  localparam logic [11:0] ADDR_DATA = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_CTRL = 12'h00C;
  localparam logic [11:0] ADDR_DES_POS = 12'h010;
  localparam logic [11:0] ADDR_TGT_POS = 12'h014;

  // ----------------------------------------------------------------
  // Control word fields, high_byte then low_byte
  // ----------------------------------------------------------------
  localparam int CW_MOTOR_OFF = 8;
  localparam int CW_ABRUPT = 9;
  localparam int CW_SMOOTH = 10;
  localparam int CW_FORWARD = 11;
  localparam int CW_VEL_MODE = 12;
  localparam int CW_STOP_LSB = 8;
  localparam int CW_POS_REL = 0;
  localparam int CW_POS_LD = 1;
  localparam int CW_VEL_REL = 2;
  localparam int CW_VEL_LD = 3;
  localparam int CW_ACC_REL = 4;
  localparam int CW_ACC_LD = 5;

  // Stop mode vector bit positions
  localparam int STOP_OFF = 0;
  localparam int STOP_ABRUPT = 1;
  localparam int STOP_SMOOTH = 2;

  // Parameter slots, in load order acc, vel, pos
  localparam int PAR_POS = 0;
  localparam int PAR_VEL = 1;
  localparam int PAR_ACC = 2;
  localparam int NUM_PAR = 3;

  // ----------------------------------------------------------------
  // Status bits
  // ----------------------------------------------------------------
  localparam int ST_BUSY = 0;
  localparam int ST_MOVING = 1;
  localparam int ST_MOTOR_OFF = 2;
  localparam int ST_LOADING = 3;

  // ----------------------------------------------------------------
  // Drive and timing
  // ----------------------------------------------------------------
  localparam int DRIVE_W = 12;
  localparam logic [11:0] DRIVE_ZERO_CODE = 12'h800;
  localparam int CLK_PERIOD_NS = 20;
  localparam int BUSY_TIME_NS = 100;
  localparam int BUSY_CYCLES = (BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAMPLE_CLKS = 2048;

  typedef enum logic [2:0] {
    TLSC_LD_IDLE = 3'b001,
    TLSC_LD_CTRL = 3'b010,
    TLSC_LD_PARAM = 3'b100
  } tlsc_ld_e;

endpackage : tlsc_pkg

// file: logic/tlsc_profile.sv
// Profile generator: desired position from working trajectory parameters
`timescale 1ns/1ns
module tlsc_profile #(
  parameter int POS_W = 32
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control from the command section
  input wire logic tick,
  input wire logic start,
  input wire logic [2:0] stop_mode,
  input wire logic vel_mode,
  input wire logic forward,
  input wire logic [POS_W-1:0] acc,
  input wire logic [POS_W-1:0] vmax,
  input wire logic [POS_W-1:0] target,
  input wire logic [POS_W-1:0] actual,
  // Results
  output logic [POS_W-1:0] desired_pos,
  output logic moving
);

  logic [POS_W-1:0] pos_q, pos_d, vel_q, vel_d, brake_q, brake_d, remain;
  logic dir_q, dir_d, run_q, run_d, follow_q, follow_d, decel_q, decel_d;
  logic slowing;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    pos_d = pos_q;
    vel_d = vel_q;
    brake_d = brake_q;
    dir_d = dir_q;
    run_d = run_q;
    follow_d = follow_q;
    decel_d = decel_q;
    remain = dir_q ? target - pos_q : pos_q - target;
    slowing = decel_q || (!vel_mode && remain <= brake_q);
    if (start) begin
      if (stop_mode[tlsc_pkg::STOP_OFF]) begin
        follow_d = 1'b1;
        run_d = 1'b0;
        decel_d = 1'b0;
        vel_d = '0;
        brake_d = '0;
      end else if (stop_mode[tlsc_pkg::STOP_ABRUPT]) begin
        pos_d = actual;
        run_d = 1'b0;
        follow_d = 1'b0;
        decel_d = 1'b0;
        vel_d = '0;
        brake_d = '0;
      end else if (stop_mode[tlsc_pkg::STOP_SMOOTH]) begin
        decel_d = run_q;
        follow_d = 1'b0;
      end else begin
        run_d = 1'b1;
        follow_d = 1'b0;
        decel_d = 1'b0;
        brake_d = '0;
        vel_d = '0;
        dir_d = vel_mode ? forward : (target >= pos_q);
      end
    end else if (follow_q) begin
      pos_d = actual;
    end else if (tick && run_q) begin
      if (!vel_mode && !decel_q && remain <= vel_q) begin
        pos_d = target;
        vel_d = '0;
        brake_d = '0;
        run_d = 1'b0;
      end else if (slowing) begin
        // Brake estimate can run short; creep at acc so a move still ends
        vel_d = (vel_q > acc) ? vel_q - acc : (decel_q ? '0 : acc);
        brake_d = (brake_q > vel_q) ? brake_q - vel_q : '0;
        pos_d = dir_q ? pos_q + vel_q : pos_q - vel_q;
        if (decel_q && vel_q == '0) begin
          run_d = 1'b0;
          decel_d = 1'b0;
        end
      end else begin
        vel_d = (vmax - vel_q > acc) ? vel_q + acc : vmax;
        brake_d = brake_q + vel_q;
        pos_d = dir_q ? pos_q + vel_q : pos_q - vel_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // State registers; zero desired position holds home after reset
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_q <= '0;
      vel_q <= '0;
      brake_q <= '0;
      dir_q <= 1'b0;
      run_q <= 1'b0;
      follow_q <= 1'b0;
      decel_q <= 1'b0;
    end else begin
      pos_q <= pos_d;
      vel_q <= vel_d;
      brake_q <= brake_d;
      dir_q <= dir_d;
      run_q <= run_d;
      follow_q <= follow_d;
      decel_q <= decel_d;
    end
  end

  assign desired_pos = pos_q;
  assign moving = run_q;

endmodule : tlsc_profile

// file: sim/tlsc_chk_sva.sv
// Assertion checker for the trajectory load and stop control block
`timescale 1ns/1ns
module tlsc_chk #(
  parameter int SAMPLE_CLKS = 2048,
  parameter int POS_W = 32
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tlsc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Servo loop side
  input wire logic [POS_W-1:0] actual_pos,
  input wire logic [tlsc_pkg::DRIVE_W-1:0] pid_drive,
  input wire logic [tlsc_pkg::DRIVE_W-1:0] motor_drive,
  input wire logic [POS_W-1:0] desired_pos,
  input wire logic in_motion
);
  // ----------------------------------------------------------------
  // Busy shadow
  // ----------------------------------------------------------------
  // The second data byte of each word also raises busy, so only the set side is claimed
  logic [2:0] busy_q;
  logic [2:0] busy_d;
  logic cmd_take;
  logic stat_rd;
  assign cmd_take = psel && penable && pready && pwrite && paddr == tlsc_pkg::ADDR_CMD;
  assign stat_rd = psel && penable && pready && !pwrite && paddr == tlsc_pkg::ADDR_STATUS;
  always_comb begin
    busy_d = busy_q;
    if (busy_q != 3'h0) begin
      busy_d = busy_q - 3'h1;
    end else if (cmd_take) begin
      busy_d = 3'h5;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 3'h0;
    end else begin
      busy_q <= busy_d;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  zero_wait_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  one_beat_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  err_zero_a: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved");
  busy_seen_a: assert property (stat_rd && busy_q >= 3'h3 |-> prdata[tlsc_pkg::ST_BUSY])
    else $error("busy not shown");
  drive_pass_a: assert property (motor_drive != tlsc_pkg::DRIVE_ZERO_CODE
    |-> motor_drive == $past(pid_drive))
    else $error("drive neither zero code nor filter");
  reset_clear_a: assert property ($rose(presetn) |-> desired_pos == '0 && !in_motion
    && motor_drive == tlsc_pkg::DRIVE_ZERO_CODE)
    else $error("reset state wrong");
  cover property (cmd_take);
  cover property ($fell(in_motion));
  cover property (pslverr);
endmodule : tlsc_chk

bind tlsc_top tlsc_chk #(.SAMPLE_CLKS(SAMPLE_CLKS), .POS_W(POS_W)) tlsc_chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .actual_pos(actual_pos), .pid_drive(pid_drive), .motor_drive(motor_drive),
  .desired_pos(desired_pos), .in_motion(in_motion));

// file: sim/tlsc_plant.sv
// Shaft and servo model on the far side of the block
`timescale 1ns/1ns
module tlsc_plant #(
  parameter int POS_W = 32
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // From the block
  input wire logic [POS_W-1:0] desired_pos,
  input wire logic [11:0] motor_drive,
  // Disturbance from the bench
  input wire logic kick,
  input wire logic [POS_W-1:0] kick_amt,
  // To the block
  output logic [POS_W-1:0] actual_pos,
  output logic [11:0] pid_drive
);
  logic [POS_W-1:0] act_q;
  logic [POS_W-1:0] act_d;
  // Crude filter: error straight onto the drive code
  assign pid_drive = tlsc_pkg::DRIVE_ZERO_CODE + 12'(desired_pos - act_q);
  assign actual_pos = act_q;
  always_comb begin
    act_d = act_q;
    if (kick) begin
      act_d = act_q + kick_amt;
    end else if (motor_drive != tlsc_pkg::DRIVE_ZERO_CODE) begin
      // Stiff loop; zero drive leaves the shaft free
      act_d = desired_pos;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_q <= '0;
    end else begin
      act_q <= act_d;
    end
  end
endmodule : tlsc_plant

// file: sim/tb_top.sv
// Self-checking bench for the trajectory load and stop control block
`timescale 1ns/1ns
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_top;
  typedef struct {string n; logic [31:0] e; logic [31:0] m;} tlsc_exp_s;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic kick = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] kick_amt = 32'h0000_0001;
  logic [31:0] lfsr_q = 32'h0001_24C3;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] actual_pos;
  logic [31:0] desired_pos;
  logic [31:0] pos;
  logic [31:0] hold;
  logic [11:0] pid_drive;
  logic [11:0] motor_drive;
  logic in_motion;
  int failures = 0;
  int check_count = 0;
  int k;
  tlsc_exp_s expq[$];
  tlsc_exp_s ex;
  tlsc_top #(.SAMPLE_CLKS(4)) tlsc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .actual_pos(actual_pos), .pid_drive(pid_drive),
    .motor_drive(motor_drive), .desired_pos(desired_pos), .in_motion(in_motion));
  tlsc_plant tlsc_plant_i (.pclk(pclk), .presetn(presetn), .desired_pos(desired_pos),
    .motor_drive(motor_drive), .kick(kick), .kick_amt(kick_amt), .actual_pos(actual_pos),
    .pid_drive(pid_drive));
  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
      input string n);
    logic [31:0] r;
    expq.push_back('{n, e, m});
    apb(1'b0, a, 32'h0000_0000, r);
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr
  // Host side polls after every command and word
  task automatic poll();
    logic [31:0] r;
    r = 32'h0000_0001;
    while (r[tlsc_pkg::ST_BUSY] !== 1'b0) begin
      expq.push_back('{"busy", 32'h0000_0000, 32'h0000_0000});
      apb(1'b0, tlsc_pkg::ADDR_STATUS, 32'h0000_0000, r);
    end
  endtask : poll
  task automatic cmd(input logic [7:0] c);
    wr(tlsc_pkg::ADDR_CMD, {24'h00_0000, c});
    poll();
  endtask : cmd
  task automatic word(input logic [15:0] v);
    wr(tlsc_pkg::ADDR_DATA, {24'h00_0000, v[15:8]});
    wr(tlsc_pkg::ADDR_DATA, {24'h00_0000, v[7:0]});
    poll();
  endtask : word
  task automatic par(input logic [31:0] v);
    word(v[31:16]);
    word(v[15:0]);
  endtask : par
  task automatic load(input logic [15:0] cw, input logic [31:0] acc, input logic [31:0] vel,
      input logic [31:0] p);
    cmd(tlsc_pkg::LOAD_TRAJECTORY_CMD);
    word(cw);
    if (cw[tlsc_pkg::CW_ACC_LD]) par(acc);
    if (cw[tlsc_pkg::CW_VEL_LD]) par(vel);
    if (cw[tlsc_pkg::CW_POS_LD]) par(p);
  endtask : load
  task automatic wait_mo(input logic lvl);
    for (int i = 0; i < 4000 && in_motion !== lvl; i++) @(negedge pclk);
    @(negedge pclk);
  endtask : wait_mo
  task automatic kick_it();
    @(posedge pclk);
    lfsr_q = lfsr_next(lfsr_q);
    kick <= 1'b1;
    kick_amt <= {24'h00_0000, lfsr_q[7:0]} + 32'h0000_0001;
    @(posedge pclk);
    kick <= 1'b0;
    repeat (5) @(posedge pclk);
    @(negedge pclk);
  endtask : kick_it
  task automatic test_done();
    if (failures == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  // ----------------------------------------------------------------
  // Processes
  // ----------------------------------------------------------------
  initial forever #10 pclk = ~pclk;
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0) begin
      ex = expq.pop_front();
      if (ex.m != 32'h0000_0000) `CHK(ex.n, ex.e & ex.m, prdata & ex.m)
    end
  end
  initial begin
    repeat (60000) @(posedge pclk);
    failures++;
    test_done();
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(tlsc_pkg::ADDR_TGT_POS, 32'h0000_0000, '1, "tgt");
    rd(tlsc_pkg::ADDR_CTRL, 32'h0000_0000, '1, "ctrl");
    rd(12'h040, 32'h0000_0000, '1, "unmapped");
    wr(12'h040, 32'hFFFF_FFFF);
    // Start without polling must be dropped, so the load stays open
    wr(tlsc_pkg::ADDR_CMD, {24'h00_0000, tlsc_pkg::LOAD_TRAJECTORY_CMD});
    wr(tlsc_pkg::ADDR_CMD, {24'h00_0000, tlsc_pkg::START_MOTION_CMD});
    poll();
    rd(tlsc_pkg::ADDR_STATUS, 32'h0000_0008, 32'h0000_0008, "loading");
    word(16'h0020);
    par(32'h0000_0001);
    cmd(tlsc_pkg::START_MOTION_CMD);
    rd(tlsc_pkg::ADDR_DES_POS, 32'h0000_0000, '1, "des");
    lfsr_q = lfsr_next(lfsr_q);
    pos = 32'h0000_0020 + {26'h000_0000, lfsr_q[5:0]};
    load(16'h000A, 32'h0000_0000, {30'h0000_0000, lfsr_q[7:6]} + 32'h0000_0001, pos);
    rd(tlsc_pkg::ADDR_TGT_POS, 32'h0000_0000, '1, "tgt");
    cmd(tlsc_pkg::START_MOTION_CMD);
    rd(tlsc_pkg::ADDR_TGT_POS, pos, '1, "tgt");
    wait_mo(1'b0);
    `CHK("desired", pos, desired_pos)
    load(16'h0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    cmd(tlsc_pkg::START_MOTION_CMD);
    rd(tlsc_pkg::ADDR_TGT_POS, pos, '1, "tgt");
    load(16'h1808, 32'h0000_0000, 32'h0000_0002, 32'h0000_0000);
    for (k = 0; k < 3; k++) begin
      cmd(tlsc_pkg::START_MOTION_CMD);
      wait_mo(1'b1);
      `CHK("moving", 1'b1, in_motion)
      load(16'(16'h0100 << k), 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
      rd(tlsc_pkg::ADDR_STATUS, 32'h0000_0002, 32'h0000_0002, "moving");
      cmd(tlsc_pkg::START_MOTION_CMD);
      rd(tlsc_pkg::ADDR_CTRL, 32'h0000_0000, 32'h0000_0700, "ctrl");
      if (k == 0) begin
        @(negedge pclk);
        `CHK("drive", tlsc_pkg::DRIVE_ZERO_CODE, motor_drive)
        kick_it();
        `CHK("follow", actual_pos, desired_pos)
      end else begin
        wait_mo(1'b0);
        `CHK("moving", 1'b0, in_motion)
        hold = desired_pos;
        kick_it();
        `CHK("hold", hold, desired_pos)
        `CHK("return", hold, actual_pos)
      end
    end
    test_done();
  end
endmodule : tb_top
